// ==== core/retimer_channel_ctrl_regs.sv ====
// Per-channel control and status register bank of a serial-data retimer.
//
// Summary of operation
// [RULE1] Writing one to bit 2 of offset channel_soft_reset returns the selected channel's registers to defaults and the bit then clears itself.
// [RULE2] Bit 4 of offset loss_interrupt_flags is a read-only flag for loss of clock-recovery lock, zero by default.
// [RULE3] Bit 0 of offset loss_interrupt_flags is a read-only flag for loss of input signal detect, zero by default.
// [RULE4] Offset recovery_lock_status reads failed lock check at bit 5, general lock at bit 4 and recovery lock at bit 3, other bits zero.
// [RULE5] The manual boost register drives the equalizer boost only while the manual boost enable is high, fields default zero.
// [RULE6] The boost value actually applied to the input equalizer reads back at offset 0x52.
// [RULE7] Boost stage 0 sits in bits 7:6, stage 1 in 5:4, stage 2 in 3:2 and stage 3 in 1:0.
// [RULE8] Offset cap_start_group0 holds the five-bit capacitor start value of group 0 in bits 4:0, default zero.
// [RULE9] Offset cap_start_group1 holds the five-bit capacitor start value of group 1 in bits 4:0, default 0x0F.
// [RULE10] With override bit 5 set the output mux select comes from its manual field, otherwise automatic.
// [RULE11] With override bit 2 set the divider select comes from its manual field, otherwise automatic.
// [RULE12] With bit 3 of offset recovery_reset_control set the recovery reset follows bit 2 of it, otherwise internal logic.
// [RULE13] Bit 3 of offset lock_qualify_control enables the single bit transition check as lock qualifier, enabled by default.
// [RULE14] Channel accesses go to the channel named by the select register at 0xFF until it is rewritten.
// [RULE15] Each loss flag sets on its event and stays set until software has read it; the code also clears it on a channel soft reset.
`timescale 1ns/1ps
`default_nettype none
module retimer_channel_ctrl_regs (
	// Clock and reset
	input  wire logic                                     clk_sys_in,
	input  wire logic                                     srst_in,
	// Register access port
	input  wire logic [7:0]                               reg_addr_in,
	input  wire logic [7:0]                               reg_wdata_in,
	input  wire logic                                     reg_wr_in,
	input  wire logic                                     reg_rd_in,
	output logic      [7:0]                               reg_rdata_out,
	output logic                                          reg_rvalid_out,
	// Per-channel status from the analog datapath
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0] lock_loss_evt_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0] sd_loss_evt_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0] fail_lock_check_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0] lock_ind_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0] recovery_lock_in,
	// Per-channel automatic choices and fields held elsewhere
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0]       manual_boost_en_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0][7:0]  auto_boost_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0][2:0]  mux_field_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0][2:0]  auto_mux_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0][2:0]  div_field_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0][2:0]  auto_div_in,
	input  wire logic [retimer_regs_pkg::NUM_CHANNELS-1:0]       auto_recovery_rst_in,
	// Per-channel controls to the datapath
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0][7:0]  applied_boost_out,
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0][2:0]  mux_sel_out,
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0][2:0]  div_sel_out,
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0]       recovery_rst_out,
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0]       sbt_check_en_out,
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0][4:0]  cap_start0_out,
	output logic      [retimer_regs_pkg::NUM_CHANNELS-1:0][4:0]  cap_start1_out
);
	localparam int unsigned NCH = retimer_regs_pkg::NUM_CHANNELS;

	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		addr_hit = (addr == off);
	endfunction

	logic [7:0]                 chan_sel_r;
	logic                       sel_idx;
	logic [NCH-1:0]             soft_rst_r;
	logic [NCH-1:0][7:0]        boost_r;
	logic [NCH-1:0][4:0]        cap0_r;
	logic [NCH-1:0][7:0]        override_r;
	logic [NCH-1:0][7:0]        rec_rst_r;
	logic [NCH-1:0][4:0]        cap1_r;
	logic [NCH-1:0][7:0]        lockq_r;
	logic [NCH-1:0]             lock_flag;
	logic [NCH-1:0]             sd_flag;
	logic [7:0]                 rdata_nxt;

	// The select register lives outside every channel and steers all channel accesses.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			chan_sel_r <= retimer_regs_pkg::DEF_CHANNEL_SEL;
		end else if (reg_wr_in && addr_hit(reg_addr_in, retimer_regs_pkg::OFF_CHANNEL_SEL)) begin
			chan_sel_r <= reg_wdata_in; // [RULE14]
		end
	end

	assign sel_idx = chan_sel_r[retimer_regs_pkg::BIT_CHSEL_INDEX]; // [RULE14]

	for (genvar g = 0; g < NCH; g++) begin : g_chan
		logic        wr_here;
		logic        rd_flags;
		loss_flag_if lock_lf ();
		loss_flag_if sd_lf ();

		assign wr_here = reg_wr_in && (sel_idx == 1'(g)) &&
			!addr_hit(reg_addr_in, retimer_regs_pkg::OFF_CHANNEL_SEL); // [RULE14]
		assign rd_flags = reg_rd_in && (sel_idx == 1'(g)) &&
			addr_hit(reg_addr_in, retimer_regs_pkg::OFF_LOSS_FLAGS);

		// The reset bit lives for one cycle only, so software never sees it stuck.
		always_ff @(posedge clk_sys_in) begin
			if (srst_in) begin
				soft_rst_r[g] <= 1'b0;
			end else begin
				soft_rst_r[g] <= wr_here && addr_hit(reg_addr_in, retimer_regs_pkg::OFF_SOFT_RESET)
					&& reg_wdata_in[retimer_regs_pkg::BIT_SOFT_RESET]; // [RULE1]
			end
		end

		// Channel reset beats a write landing in the same cycle.
		always_ff @(posedge clk_sys_in) begin
			if (srst_in || soft_rst_r[g]) begin // [RULE1]
				boost_r[g]    <= retimer_regs_pkg::DEF_MANUAL_BOOST; // [RULE5]
				cap0_r[g]     <= retimer_regs_pkg::DEF_CAP_START0; // [RULE8]
				override_r[g] <= retimer_regs_pkg::DEF_OVERRIDE;
				rec_rst_r[g]  <= retimer_regs_pkg::DEF_RECOVERY_RST;
				cap1_r[g]     <= retimer_regs_pkg::DEF_CAP_START1; // [RULE9]
				lockq_r[g]    <= retimer_regs_pkg::DEF_LOCK_QUALIFY; // [RULE13]
			end else if (wr_here) begin
				unique case (reg_addr_in)
					retimer_regs_pkg::OFF_MANUAL_BOOST: boost_r[g] <= reg_wdata_in; // [RULE7]
					retimer_regs_pkg::OFF_CAP_START0: cap0_r[g] <= reg_wdata_in[4:0]; // [RULE8]
					retimer_regs_pkg::OFF_OVERRIDE: override_r[g] <= reg_wdata_in;
					retimer_regs_pkg::OFF_RECOVERY_RST: rec_rst_r[g] <= reg_wdata_in;
					retimer_regs_pkg::OFF_CAP_START1: cap1_r[g] <= reg_wdata_in[4:0]; // [RULE9]
					retimer_regs_pkg::OFF_LOCK_QUALIFY: lockq_r[g] <= reg_wdata_in;
					default: ;
				endcase
			end
		end

		assign lock_lf.event_seen = lock_loss_evt_in[g]; // [RULE2]
		assign lock_lf.clear_req  = rd_flags || soft_rst_r[g];
		assign sd_lf.event_seen   = sd_loss_evt_in[g]; // [RULE3]
		assign sd_lf.clear_req    = rd_flags || soft_rst_r[g];
		assign lock_flag[g]       = lock_lf.flag;
		assign sd_flag[g]         = sd_lf.flag;

		loss_flag_keeper u_lock_flag (
			.clk_sys_in (clk_sys_in),
			.srst_in    (srst_in),
			.lf         (lock_lf.keeper)
		);

		loss_flag_keeper u_sd_flag (
			.clk_sys_in (clk_sys_in),
			.srst_in    (srst_in),
			.lf         (sd_lf.keeper)
		);

		override_select #(.WIDTH(8), .RESET_VAL(retimer_regs_pkg::DEF_APPLIED)) u_boost (
			.clk_sys_in  (clk_sys_in),
			.srst_in     (srst_in),
			.override_in (manual_boost_en_in[g]), // [RULE5]
			.manual_in   (boost_r[g]),
			.auto_in     (auto_boost_in[g]),
			.value_out   (applied_boost_out[g])
		);

		override_select #(.WIDTH(3), .RESET_VAL(3'h0)) u_mux (
			.clk_sys_in  (clk_sys_in),
			.srst_in     (srst_in),
			.override_in (override_r[g][retimer_regs_pkg::BIT_MUX_OVR_EN]), // [RULE10]
			.manual_in   (mux_field_in[g]),
			.auto_in     (auto_mux_in[g]),
			.value_out   (mux_sel_out[g])
		);

		override_select #(.WIDTH(3), .RESET_VAL(3'h0)) u_div (
			.clk_sys_in  (clk_sys_in),
			.srst_in     (srst_in),
			.override_in (override_r[g][retimer_regs_pkg::BIT_DIV_OVR_EN]), // [RULE11]
			.manual_in   (div_field_in[g]),
			.auto_in     (auto_div_in[g]),
			.value_out   (div_sel_out[g])
		);

		override_select #(.WIDTH(1), .RESET_VAL(1'h0)) u_rec_rst (
			.clk_sys_in  (clk_sys_in),
			.srst_in     (srst_in),
			.override_in (rec_rst_r[g][retimer_regs_pkg::BIT_RST_OVR_EN]), // [RULE12]
			.manual_in   (rec_rst_r[g][retimer_regs_pkg::BIT_RST_OVR_VAL]),
			.auto_in     (auto_recovery_rst_in[g]),
			.value_out   (recovery_rst_out[g])
		);

		assign sbt_check_en_out[g] = lockq_r[g][retimer_regs_pkg::BIT_SBT_EN]; // [RULE13]
		assign cap_start0_out[g]   = cap0_r[g];
		assign cap_start1_out[g]   = cap1_r[g];
	end

	// Read data for the selected channel; unmapped offsets read as zero.
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (reg_addr_in)
			retimer_regs_pkg::OFF_SOFT_RESET:
				rdata_nxt[retimer_regs_pkg::BIT_SOFT_RESET] = soft_rst_r[sel_idx]; // [RULE1]
			retimer_regs_pkg::OFF_LOSS_FLAGS: begin
				rdata_nxt[retimer_regs_pkg::BIT_LOCK_LOSS] = lock_flag[sel_idx]; // [RULE2]
				rdata_nxt[retimer_regs_pkg::BIT_SD_LOSS]   = sd_flag[sel_idx]; // [RULE3]
			end
			retimer_regs_pkg::OFF_LOCK_STATUS: begin
				rdata_nxt[retimer_regs_pkg::BIT_FAIL_CHECK]    = fail_lock_check_in[sel_idx]; // [RULE4]
				rdata_nxt[retimer_regs_pkg::BIT_LOCK_IND]      = lock_ind_in[sel_idx]; // [RULE4]
				rdata_nxt[retimer_regs_pkg::BIT_RECOVERY_LOCK] = recovery_lock_in[sel_idx]; // [RULE4]
			end
			retimer_regs_pkg::OFF_MANUAL_BOOST: rdata_nxt = boost_r[sel_idx];
			retimer_regs_pkg::OFF_CAP_START0: rdata_nxt = {3'h0, cap0_r[sel_idx]};
			retimer_regs_pkg::OFF_OVERRIDE: rdata_nxt = override_r[sel_idx];
			retimer_regs_pkg::OFF_RECOVERY_RST: rdata_nxt = rec_rst_r[sel_idx];
			retimer_regs_pkg::OFF_CAP_START1: rdata_nxt = {3'h0, cap1_r[sel_idx]};
			retimer_regs_pkg::OFF_LOCK_QUALIFY: rdata_nxt = lockq_r[sel_idx];
			retimer_regs_pkg::OFF_APPLIED_BOOST: rdata_nxt = applied_boost_out[sel_idx]; // [RULE6]
			retimer_regs_pkg::OFF_CHANNEL_SEL: rdata_nxt = chan_sel_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_out <= rdata_nxt;
			end
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	sequence reset_write_s;
		reg_wr_in && !sel_idx && (reg_addr_in == 8'h00) && reg_wdata_in[2];
	endsequence

	sequence pulse_once_s;
		soft_rst_r[0] ##1 !soft_rst_r[0];
	endsequence

	soft_reset_pulse_a: assert property (reset_write_s |=> pulse_once_s) // [RULE1]
		else $error("channel reset bit did not pulse once");

	soft_reset_defaults_a: assert property (reset_write_s |=> ##1 (cap1_r[0] == 5'h0F) && // [RULE1]
		(lockq_r[0] == 8'h08) && (boost_r[0] == 8'h00) && (rec_rst_r[0] == 8'h10))
		else $error("channel registers not back at defaults after channel reset");

	lock_loss_set_a: assert property (lock_loss_evt_in[0] |=> lock_flag[0] [*2]) // [RULE2]
		else $error("lock loss flag not set and held");

	sd_loss_hold_a: assert property (sd_flag[0] && !g_chan[0].rd_flags && !soft_rst_r[0] // [RULE15]
		|=> sd_flag[0])
		else $error("signal detect loss flag dropped before read");

	status_read_a: assert property (reg_rd_in && (reg_addr_in == 8'h02) |=> // [RULE4]
		reg_rvalid_out && (reg_rdata_out[5] == $past(fail_lock_check_in[sel_idx])) &&
		(reg_rdata_out[3] == $past(recovery_lock_in[sel_idx])) &&
		(reg_rdata_out[7:6] == 2'h0) && (reg_rdata_out[2:0] == 3'h0))
		else $error("recovery status read back wrong");

	boost_apply_a: assert property (##1 applied_boost_out[0] == // [RULE5]
		($past(manual_boost_en_in[0]) ? $past(boost_r[0]) : $past(auto_boost_in[0])))
		else $error("applied boost does not follow the manual enable");

	mux_override_a: assert property (override_r[0][5] |=> mux_sel_out[0] == $past(mux_field_in[0])) // [RULE10]
		else $error("mux override not applied");

	div_override_a: assert property (!override_r[0][2] |=> div_sel_out[0] == $past(auto_div_in[0])) // [RULE11]
		else $error("divider select not automatic without override");

	recovery_reset_a: assert property (rec_rst_r[0][3] |=> recovery_rst_out[0] == $past(rec_rst_r[0][2])) // [RULE12]
		else $error("recovery reset does not follow its override value");

	channel_route_a: assert property (reg_wr_in && sel_idx && (reg_addr_in == 8'h0C) // [RULE14]
		&& !soft_rst_r[0] && !soft_rst_r[1] |=> (lockq_r[1] == $past(reg_wdata_in)) && $stable(lockq_r[0]))
		else $error("write reached the wrong channel");
endmodule
`default_nettype wire

// ==== core/retimer_regs_pkg.sv ====
// Constants for the retimer per-channel control and status register bank.
package retimer_regs_pkg;
	localparam int unsigned NUM_CHANNELS = 2;

	// Register offsets inside the selected channel, plus the shared channel select at 0xFF.
	localparam logic [7:0] OFF_SOFT_RESET    = 8'h00;
	localparam logic [7:0] OFF_LOSS_FLAGS    = 8'h01;
	localparam logic [7:0] OFF_LOCK_STATUS   = 8'h02;
	localparam logic [7:0] OFF_MANUAL_BOOST  = 8'h03;
	localparam logic [7:0] OFF_CAP_START0    = 8'h08;
	localparam logic [7:0] OFF_OVERRIDE      = 8'h09;
	localparam logic [7:0] OFF_RECOVERY_RST  = 8'h0A;
	localparam logic [7:0] OFF_CAP_START1    = 8'h0B;
	localparam logic [7:0] OFF_LOCK_QUALIFY  = 8'h0C;
	localparam logic [7:0] OFF_APPLIED_BOOST = 8'h52;
	localparam logic [7:0] OFF_CHANNEL_SEL   = 8'hFF;

	// Field positions.
	localparam int unsigned BIT_SOFT_RESET    = 2;
	localparam int unsigned BIT_LOCK_LOSS     = 4;
	localparam int unsigned BIT_SD_LOSS       = 0;
	localparam int unsigned BIT_FAIL_CHECK    = 5;
	localparam int unsigned BIT_LOCK_IND      = 4;
	localparam int unsigned BIT_RECOVERY_LOCK = 3;
	localparam int unsigned BIT_MUX_OVR_EN    = 5;
	localparam int unsigned BIT_DIV_OVR_EN    = 2;
	localparam int unsigned BIT_RST_OVR_EN    = 3;
	localparam int unsigned BIT_RST_OVR_VAL   = 2;
	localparam int unsigned BIT_SBT_EN        = 3;
	localparam int unsigned BIT_CHSEL_INDEX   = 0;
	localparam int unsigned CAP_WIDTH         = 5;

	// Values after reset.
	localparam logic [7:0] DEF_MANUAL_BOOST = 8'h00;
	localparam logic [4:0] DEF_CAP_START0   = 5'h00;
	localparam logic [7:0] DEF_OVERRIDE     = 8'h00;
	localparam logic [7:0] DEF_RECOVERY_RST = 8'h10;
	localparam logic [4:0] DEF_CAP_START1   = 5'h0F;
	localparam logic [7:0] DEF_LOCK_QUALIFY = 8'h08;
	localparam logic [7:0] DEF_CHANNEL_SEL  = 8'h00;
	localparam logic [7:0] DEF_APPLIED      = 8'h00;
endpackage

// ==== core/loss_flag_if.sv ====
// Signals between the register bank and one sticky loss flag.
`timescale 1ns/1ps
`default_nettype none
interface loss_flag_if;
	logic event_seen;
	logic clear_req;
	logic flag;
	modport keeper (input event_seen, input clear_req, output flag);
	modport owner (output event_seen, output clear_req, input flag);
endinterface
`default_nettype wire

// ==== core/loss_flag_keeper.sv ====
// One sticky loss flag: set by its event, cleared when software reads it.
`timescale 1ns/1ps
`default_nettype none
module loss_flag_keeper (
	// Clock and reset
	input  wire logic   clk_sys_in,
	input  wire logic   srst_in,
	// Flag link
	loss_flag_if.keeper lf
);
	logic flag_r;

	// A loss that lands in the clearing cycle is kept, so set wins.
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			flag_r <= 1'b0;
		end else if (lf.event_seen) begin
			flag_r <= 1'b1; // [RULE15]
		end else if (lf.clear_req) begin
			flag_r <= 1'b0;
		end
	end

	assign lf.flag = flag_r;
endmodule
`default_nettype wire

// ==== core/override_select.sv ====
// Registered choice between an automatic value and a software override.
`timescale 1ns/1ps
`default_nettype none
module override_select #(
	parameter int unsigned     WIDTH     = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             srst_in,
	// Choice
	input  wire logic             override_in,
	input  wire logic [WIDTH-1:0] manual_in,
	input  wire logic [WIDTH-1:0] auto_in,
	output logic      [WIDTH-1:0] value_out
);
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			value_out <= RESET_VAL;
		end else begin
			value_out <= override_in ? manual_in : auto_in;
		end
	end
endmodule
`default_nettype wire

// ==== tb/reg_host_model.sv ====
// Register host model that drives the bank's access port one strobe at a time.
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
	// Clock
	input  wire logic       clk_sys_in,
	// Register access port
	output logic      [7:0] reg_addr_out,
	output logic      [7:0] reg_wdata_out,
	output logic            reg_wr_out,
	output logic            reg_rd_out
);
	initial begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end

	// Released lines show the inverse so a stale address can never pass for a live one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		reg_addr_out = a;
		reg_wdata_out = d;
		reg_wr_out = 1'b1;
		@(negedge clk_sys_in);
		reg_wr_out = 1'b0;
		reg_addr_out = ~a;
		reg_wdata_out = ~d;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge clk_sys_in);
		reg_addr_out = a;
		reg_rd_out = 1'b1;
		@(negedge clk_sys_in);
		reg_rd_out = 1'b0;
		reg_addr_out = ~a;
	endtask

	// All later channel accesses stay on this channel until it is rewritten.
	task automatic sel(input logic ch);
		wr(8'hFF, {7'h00, ch});
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking testbench for the retimer channel register bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int NC = retimer_regs_pkg::NUM_CHANNELS;
	localparam logic [7:0] DA [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09,
		8'h0A, 8'h0B, 8'h0C, 8'h52, 8'hFF, 8'h05};
	localparam logic [7:0] DV [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h10, 8'h0F, 8'h08, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] WA [6] = '{8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
	localparam logic [7:0] WM [6] = '{8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h1F, 8'hFF};
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
	logic reg_wr_in, reg_rd_in, reg_rvalid_out;
	logic [NC-1:0] lock_loss_evt_in = '0, sd_loss_evt_in = '0, fail_lock_check_in = '0;
	logic [NC-1:0] lock_ind_in = '0, recovery_lock_in = '0, manual_boost_en_in = '0;
	logic [NC-1:0] auto_recovery_rst_in = '0, recovery_rst_out, sbt_check_en_out;
	logic [NC-1:0][7:0] auto_boost_in = '0, applied_boost_out;
	logic [NC-1:0][2:0] mux_field_in = '0, auto_mux_in = '0, div_field_in = '0, auto_div_in = '0;
	logic [NC-1:0][2:0] mux_sel_out, div_sel_out;
	logic [NC-1:0][4:0] cap_start0_out, cap_start1_out;
	logic [31:0] seed = 32'h0000_0035;
	logic [7:0] exp_q [$];
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	always #50 clk_sys_in = ~clk_sys_in;

	retimer_channel_ctrl_regs u_retimer_channel_ctrl_regs (.clk_sys_in, .srst_in,
		.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out,
		.lock_loss_evt_in, .sd_loss_evt_in, .fail_lock_check_in, .lock_ind_in,
		.recovery_lock_in, .manual_boost_en_in, .auto_boost_in, .mux_field_in, .auto_mux_in,
		.div_field_in, .auto_div_in, .auto_recovery_rst_in, .applied_boost_out, .mux_sel_out,
		.div_sel_out, .recovery_rst_out, .sbt_check_en_out, .cap_start0_out, .cap_start1_out);

	reg_host_model host (.clk_sys_in, .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
		.reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in));

	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask

	task automatic waitc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Read data is valid only in the cycle after the strobe, so it is sampled mid-cycle.
	always @(negedge clk_sys_in) begin
		if (reg_rvalid_out === 1'b1) begin
			if (exp_q.size() == 0) begin
				num_errors++;
				$display("CHECK FAILED read valid expected none seen %h", reg_rdata_out);
			end else begin
				check("read data", reg_rdata_out, exp_q.pop_front());
			end
		end
	end

	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			$display("CHECK FAILED run length expected 3000 seen more");
			print_verdict();
		end
	end

	initial begin
		logic [7:0] v;
		logic [4:0] c1;
		c1 = 5'h00;
		waitc(6);
		srst_in = 1'b0;
		for (int i = 0; i < 12; i++) rdx(DA[i], DV[i]);
		check("cap start 1", {3'h0, cap_start1_out[0]}, 8'h0F);
		check("sbt enable", {6'h00, sbt_check_en_out}, 8'h03);
		$display("test defaults done");
		for (int i = 0; i < 6; i++) begin
			v = 8'(rnd());
			if (WA[i] == 8'h0B) c1 = v[4:0];
			host.wr(WA[i], v);
			rdx(WA[i], v & WM[i]);
		end
		host.wr(8'h01, 8'hFF);
		host.wr(8'h02, 8'hFF);
		rdx(8'h01, 8'h00);
		$display("test read write done");
		for (int k = 0; k < 2; k++) begin
			@(negedge clk_sys_in);
			lock_loss_evt_in = (k == 0) ? 2'b01 : 2'b00;
			sd_loss_evt_in = (k == 1) ? 2'b01 : 2'b00;
			@(negedge clk_sys_in);
			lock_loss_evt_in = '0;
			sd_loss_evt_in = '0;
			waitc(2);
			rdx(8'h01, (k == 0) ? 8'h10 : 8'h01);
			rdx(8'h01, 8'h00);
		end
		for (int k = 0; k < 4; k++) begin
			v = 8'(rnd());
			fail_lock_check_in = {~v[0], v[0]};
			lock_ind_in = {~v[1], v[1]};
			recovery_lock_in = {~v[2], v[2]};
			rdx(8'h02, {2'b00, v[0], v[1], v[2], 3'b000});
		end
		$display("test status done");
		auto_boost_in = {8'(rnd()), 8'(rnd())};
		manual_boost_en_in = 2'b01;
		v = 8'(rnd());
		host.wr(8'h03, v);
		waitc(3);
		check("manual boost", applied_boost_out[0], v);
		rdx(8'h52, v);
		manual_boost_en_in = 2'b00;
		waitc(3);
		check("auto boost", applied_boost_out[0], auto_boost_in[0]);
		rdx(8'h52, auto_boost_in[0]);
		$display("test boost done");
		for (int k = 0; k < 4; k++) begin
			v = 8'(rnd());
			mux_field_in = {v[2:0], v[5:3]};
			auto_mux_in = ~mux_field_in;
			div_field_in = {v[5:3], v[2:0]};
			auto_div_in = ~div_field_in;
			auto_recovery_rst_in = {1'b0, k[0]};
			host.wr(8'h09, {2'b00, k[0], 2'b00, k[1], 2'b00});
			host.wr(8'h0A, {4'h1, k[1], ~k[0], 2'b00});
			host.wr(8'h0C, {4'h0, k[0], 3'h0});
			waitc(3);
			check("mux select", mux_sel_out[0], k[0] ? mux_field_in[0] : auto_mux_in[0]);
			check("div select", div_sel_out[0], k[1] ? div_field_in[0] : auto_div_in[0]);
			check("recovery reset", {7'h00, recovery_rst_out[0]}, {7'h00, (k[1] ? ~k[0] : k[0])});
			check("sbt enable", sbt_check_en_out[0], k[0]);
		end
		$display("test overrides done");
		host.sel(1'b1);
		host.wr(8'h0B, 8'h05);
		host.wr(8'h0C, 8'h00);
		waitc(3);
		check("sbt per channel", {6'h00, sbt_check_en_out}, 8'h01);
		rdx(8'h0B, 8'h05);
		host.wr(8'h00, 8'h04);
		waitc(3);
		check("reset cap", {3'h0, cap_start1_out[1]}, 8'h0F);
		check("other channel", {3'h0, cap_start1_out[0]}, {3'h0, c1});
		check("reset sbt", {6'h00, sbt_check_en_out}, 8'h03);
		rdx(8'h00, 8'h00);
		rdx(8'h0B, 8'h0F);
		host.sel(1'b0);
		host.wr(8'h00, 8'h04);
		waitc(3);
		check("reset cap ch0", {3'h0, cap_start1_out[0]}, 8'h0F);
		rdx(8'h0C, 8'h08);
		$display("test channel reset done");
		waitc(3);
		print_verdict();
	end
endmodule
`default_nettype wire
